// *** rtl/tcs_pkg.sv ***
// tcs_pkg: constants and types shared by the transfer controller files
package tcs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [31:0] TCS_ADDR_REFRESH_CONTROL = 32'h01820000;
	localparam logic [31:0] TCS_ADDR_MIN_CYCLES = 32'h01820004;
	localparam logic [31:0] TCS_ADDR_MAX_CYCLES = 32'h01820008;
	localparam logic [31:0] TCS_ADDR_FAULT_CAUSE = 32'h0182000C;

	localparam int TCS_INTERVAL_LSB = 0;
	localparam int TCS_INTERVAL_MSB = 15;
	localparam int TCS_RELOAD_LSB = 16;
	localparam int TCS_RELOAD_MSB = 31;

	localparam logic [31:0] TCS_REFRESH_CONTROL_RST = 32'h00FF0040;
	localparam logic [31:0] TCS_MIN_CYCLES_RST = 32'h00000010;
	localparam logic [31:0] TCS_MAX_CYCLES_RST = 32'h00000100;

	localparam int TCS_FAULT_CACHE_LSB = 0;
	localparam int TCS_FAULT_PT_LSB = 4;
	localparam int TCS_FAULT_EXT_BIT = 8;
	localparam int TCS_FAULT_HOST_BIT = 9;
	localparam int TCS_FAULT_W = 10;

	// parameter table lengths in words
	localparam logic [4:0] TCS_PARAM_SHORT_WORDS = 5'h08;
	localparam logic [4:0] TCS_PARAM_LONG_WORDS = 5'h10;

	// ----------------------------------------------------------------
	// cycle-status codes
	// ----------------------------------------------------------------
	localparam logic [5:0] TCS_ROW_READ = 6'h00;
	localparam logic [5:0] TCS_ROW_REFRESH = 6'h02;
	localparam logic [5:0] TCS_ROW_DCAB = 6'h03;
	localparam logic [5:0] TCS_ROW_PERIPH = 6'h04;
	localparam logic [5:0] TCS_ROW_BLOCK_WRITE = 6'h09;
	localparam logic [5:0] TCS_ROW_MRS = 6'h0C;
	localparam logic [5:0] TCS_ROW_LOAD_COLOR = 6'h0D;
	localparam logic [5:0] TCS_ROW_FRAME = 6'h10;
	localparam logic [5:0] TCS_ROW_PT = 6'h1C;
	localparam logic [5:0] TCS_ROW_IDLE = 6'h1F;
	localparam logic [5:0] TCS_COL_HOST_PT = 6'h10;
	localparam logic [5:0] TCS_COL_EXT_BUSY = 6'h14;
	localparam logic [5:0] TCS_COL_EXT_DONE = 6'h15;
	localparam logic [5:0] TCS_COL_HOST_FILL = 6'h16;
	localparam logic [5:0] TCS_COL_FRAME0 = 6'h1C;
	localparam logic [5:0] TCS_COL_FRAME1 = 6'h1D;
	localparam logic [5:0] TCS_COL_REFRESH = 6'h1E;
	localparam logic [5:0] TCS_COL_IDLE = 6'h1F;
	localparam logic [5:0] TCS_COL_DRAIN = 6'h3F;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TCS_K_NORMAL, TCS_K_REFRESH, TCS_K_DCAB, TCS_K_MRS, TCS_K_LOAD_COLOR,
		TCS_K_PERIPH, TCS_K_BLOCK_WRITE, TCS_K_FRAME, TCS_K_PT, TCS_K_EXT
	} tcs_kind_t;

	typedef enum logic [1:0] {TCS_SRC_CORE, TCS_SRC_HOST, TCS_SRC_EXT, TCS_SRC_UNIT} tcs_src_t;

	typedef enum logic [1:0] {TCS_IDLE, TCS_ROW, TCS_COL} tcs_state_t;

endpackage : tcs_pkg

// *** rtl/tcs_status_code.sv ***
// tcs_status_code: registered cycle-status code for row and column time
module tcs_status_code (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// cycle phase
	input wire logic row_time,
	input wire logic col_time,
	input wire logic last_col,
	// cycle descriptor
	input wire tcs_pkg::tcs_kind_t kind,
	input wire tcs_pkg::tcs_src_t src,
	input wire logic [1:0] core,
	input wire logic [1:0] sub,
	input wire logic [2:0] chan,
	input wire logic frame,
	input wire logic write,
	input wire logic hi_prio,
	input wire logic urgent,
	// status pins
	output logic [5:0] status_code
);
	import tcs_pkg::*;

	logic [5:0] row_c;
	logic [5:0] col_c;

	always_comb begin
		row_c = TCS_ROW_IDLE;
		unique case (kind)
			TCS_K_NORMAL: row_c = TCS_ROW_READ | {5'h00, write}; // RQ15
			TCS_K_REFRESH: row_c = TCS_ROW_REFRESH; // RQ15
			TCS_K_DCAB: row_c = TCS_ROW_DCAB; // RQ15
			TCS_K_MRS: row_c = TCS_ROW_MRS; // RQ15
			TCS_K_LOAD_COLOR: row_c = TCS_ROW_LOAD_COLOR; // RQ15
			TCS_K_PERIPH: row_c = TCS_ROW_PERIPH | {5'h00, write}; // RQ16
			TCS_K_BLOCK_WRITE: row_c = TCS_ROW_BLOCK_WRITE; // RQ16
			TCS_K_FRAME: row_c = TCS_ROW_FRAME | {3'b000, frame, sub}; // RQ17
			TCS_K_PT: row_c = TCS_ROW_PT | {5'h00, write}; // RQ16
			TCS_K_EXT: begin
				// channel zero has no code of its own, so it shows idle
				if (chan != 3'b000) begin
					row_c = {1'b1, chan, sub}; // RQ18 RQ24
				end
			end
		endcase
	end

	always_comb begin
		col_c = TCS_COL_IDLE;
		unique case (src)
			TCS_SRC_CORE: col_c = {2'b00, core, sub}; // RQ19
			TCS_SRC_HOST: begin
				if (kind == TCS_K_PT) begin
					col_c = TCS_COL_HOST_PT | {4'h0, urgent, hi_prio}; // RQ20 RQ21
				end else if (sub != 2'b11) begin
					col_c = TCS_COL_HOST_FILL + {3'b000, sub, hi_prio}; // RQ20 RQ21 RQ24
				end
			end
			TCS_SRC_EXT: col_c = last_col ? TCS_COL_EXT_DONE : TCS_COL_EXT_BUSY; // RQ20
			TCS_SRC_UNIT: begin
				if (kind == TCS_K_REFRESH) begin
					col_c = TCS_COL_REFRESH; // RQ22
				end else if (kind == TCS_K_FRAME) begin
					col_c = frame ? TCS_COL_FRAME1 : TCS_COL_FRAME0; // RQ22
				end else if (kind == TCS_K_DCAB) begin
					col_c = TCS_COL_DRAIN; // RQ22
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status_code <= TCS_ROW_IDLE;
		end else if (row_time) begin
			status_code <= row_c; // RQ13
		end else if (col_time) begin
			status_code <= col_c; // RQ13
		end else begin
			status_code <= TCS_COL_IDLE;
		end
	end

	property p_idle_code;
		@(posedge clk) disable iff (rst) !row_time && !col_time |=> status_code == TCS_COL_IDLE;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle cycle without idle code"); // RQ15

	property p_ext_row;
		@(posedge clk) disable iff (rst)
			row_time && kind == TCS_K_EXT && chan != 3'b000 |=> status_code == {1'b1, $past(chan), $past(sub)};
	endproperty
	a_ext_row: assert property (p_ext_row) else $error("external channel row code wrong"); // RQ18

	property p_core_col;
		@(posedge clk) disable iff (rst)
			col_time && src == TCS_SRC_CORE |=> status_code[5:4] == 2'b00 && status_code[3:2] == $past(core);
	endproperty
	a_core_col: assert property (p_core_col) else $error("core column code wrong"); // RQ19

	property p_no_reserved_col;
		@(posedge clk) disable iff (rst) col_time |=> !status_code[5] || status_code == TCS_COL_DRAIN;
	endproperty
	a_no_reserved_col: assert property (p_no_reserved_col) else $error("reserved column code driven"); // RQ24

endmodule : tcs_status_code

// *** rtl/tcs_controller.sv ***
// tcs_controller: transfer controller sequencing, registers and cycle status
// Notes on behaviour
// [RQ1] serve cache fills, direct accesses, block moves, external, frame, refresh, host requests
// [RQ2] column width follows the sampled bus size: 8, 16, 32 or 64 bits
// [RQ3] block moves read at the source address, write at an independent destination
// [RQ4] four host-visible registers, refresh control first at 0x01820000
// [RQ5] refresh control holds pseudo-address reload and refresh interval in clocks
// [RQ6] a block move is not pre-empted before the minimum cycle count
// [RQ7] after the minimum, a block move times out at the maximum count
// [RQ8] fault status records the cause; writing one clears a bit
// [RQ9] fault flags: per-core cache/direct, per-core block move, external, host block move
// [RQ10] requester puts the parameter table on a 64-byte boundary first
// [RQ11] accept requests from host, cores, external; short and long tables
// [RQ12] big-endian mode swaps the words of the parameter table
// [RQ13] status shows cycle type at row time, requester at column time
// [RQ14] outside logic may latch the row code for bank decode
// [RQ15] row codes for read, write, refresh, deactivate, mode set, colour, idle
// [RQ16] row codes for peripheral, block-write and block-move transfers
// [RQ17] frame transfers 0100xx and 0101xx, low bits pick the transfer type
// [RQ18] external channels 1 to 7 use 1nnnxx row codes
// [RQ19] core column code 00nnxx with low bits picking the access kind
// [RQ20] column codes 010000 to 011011 name host activity
// [RQ21] low or high variant follows the host priority mode
// [RQ22] other column codes: frames, refresh, idle, drain
// [RQ23] full address at row time, column address placed by align select
// [RQ24] never drive a reserved status code
module tcs_controller (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host core register access
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// transfer requests
	input wire logic req_valid,
	output logic req_ready,
	input wire tcs_pkg::tcs_kind_t req_kind,
	input wire tcs_pkg::tcs_src_t req_src,
	input wire logic [1:0] req_core,
	input wire logic [1:0] req_sub,
	input wire logic [2:0] req_chan,
	input wire logic req_frame,
	input wire logic req_write,
	input wire logic req_hi_prio,
	input wire logic req_urgent,
	input wire logic req_long_form,
	input wire logic [31:0] req_src_addr,
	input wire logic [31:0] req_dst_addr,
	input wire logic [3:0] req_bytes,
	// parameter table words
	input wire logic big_endian,
	input wire logic [63:0] param_word,
	output logic [63:0] param_word_ord,
	output logic [4:0] pt_param_words,
	// external memory pins
	input wire logic [1:0] mem_bus_size,
	input wire logic [2:0] mem_align_sel,
	input wire logic mem_fault_n,
	output logic [31:0] mem_addr,
	output logic [5:0] mem_status,
	output logic mem_row_time,
	output logic mem_col_time,
	// events
	output logic pt_suspend,
	output logic pt_timeout,
	output logic xfer_done
);
	import tcs_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] bs_s1;
	logic [1:0] bs_s2;
	logic [2:0] as_s1;
	logic [2:0] as_s2;
	logic fault_n_s1;
	logic fault_n_s2;

	always_ff @(posedge clk) begin
		if (rst) begin
			bs_s1 <= 2'h0;
			bs_s2 <= 2'h0;
			as_s1 <= 3'h0;
			as_s2 <= 3'h0;
			fault_n_s1 <= 1'b1;
			fault_n_s2 <= 1'b1;
		end else begin
			bs_s1 <= mem_bus_size;
			bs_s2 <= bs_s1;
			as_s1 <= mem_align_sel;
			as_s2 <= as_s1;
			fault_n_s1 <= mem_fault_n;
			fault_n_s2 <= fault_n_s1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] r);
		reg_hit = (a == r);
	endfunction : reg_hit

	logic [31:0] refresh_control;
	logic [31:0] transfer_min_cycles;
	logic [31:0] transfer_max_cycles;
	logic [TCS_FAULT_W-1:0] fault_cause;
	logic [TCS_FAULT_W-1:0] fault_set;
	logic [TCS_FAULT_W-1:0] fault_clr;
	logic reg_write;

	assign reg_write = reg_sel && reg_wr;

	always_ff @(posedge clk) begin
		if (rst) begin
			refresh_control <= TCS_REFRESH_CONTROL_RST;
			transfer_min_cycles <= TCS_MIN_CYCLES_RST;
			transfer_max_cycles <= TCS_MAX_CYCLES_RST;
		end else if (reg_write) begin
			if (reg_hit(reg_addr, TCS_ADDR_REFRESH_CONTROL)) begin
				refresh_control <= reg_wdata; // RQ4 RQ5
			end
			if (reg_hit(reg_addr, TCS_ADDR_MIN_CYCLES)) begin
				transfer_min_cycles <= reg_wdata; // RQ4
			end
			if (reg_hit(reg_addr, TCS_ADDR_MAX_CYCLES)) begin
				transfer_max_cycles <= reg_wdata; // RQ4
			end
		end
	end

	assign fault_clr = (reg_write && reg_hit(reg_addr, TCS_ADDR_FAULT_CAUSE)) ? reg_wdata[TCS_FAULT_W-1:0]
		: '0;

	// a fault arriving with the clearing write survives it
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_cause <= '0;
		end else begin
			fault_cause <= (fault_cause & ~fault_clr) | fault_set; // RQ8
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_sel && !reg_wr) begin
			if (reg_hit(reg_addr, TCS_ADDR_REFRESH_CONTROL)) begin
				reg_rdata <= refresh_control;
			end else if (reg_hit(reg_addr, TCS_ADDR_MIN_CYCLES)) begin
				reg_rdata <= transfer_min_cycles;
			end else if (reg_hit(reg_addr, TCS_ADDR_MAX_CYCLES)) begin
				reg_rdata <= transfer_max_cycles;
			end else if (reg_hit(reg_addr, TCS_ADDR_FAULT_CAUSE)) begin
				reg_rdata <= {{(32-TCS_FAULT_W){1'b0}}, fault_cause}; // RQ8
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// refresh timer
	// ----------------------------------------------------------------
	logic [15:0] refresh_count;
	logic [15:0] pseudo_addr;
	logic refresh_pend;
	logic take_refresh;
	logic take_req;
	tcs_state_t state;

	always_ff @(posedge clk) begin
		if (rst) begin
			refresh_count <= 16'h0000;
		end else if (refresh_count == 16'h0000) begin
			refresh_count <= refresh_control[TCS_INTERVAL_MSB:TCS_INTERVAL_LSB]; // RQ5
		end else begin
			refresh_count <= refresh_count - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			refresh_pend <= 1'b0;
		end else begin
			refresh_pend <= (refresh_count == 16'h0000) || (refresh_pend && !take_refresh);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pseudo_addr <= 16'h0000;
		end else if (take_refresh) begin
			if (pseudo_addr == 16'h0000) begin
				pseudo_addr <= refresh_control[TCS_RELOAD_MSB:TCS_RELOAD_LSB]; // RQ5
			end else begin
				pseudo_addr <= pseudo_addr - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// request acceptance and cycle descriptor
	// ----------------------------------------------------------------
	tcs_kind_t cur_kind;
	tcs_src_t cur_src;
	logic [1:0] cur_core;
	logic [1:0] cur_sub;
	logic [2:0] cur_chan;
	logic cur_frame;
	logic cur_write;
	logic cur_hi;
	logic cur_urgent;
	logic [31:0] cur_src_addr;
	logic [31:0] cur_dst_addr;
	logic [3:0] cur_bytes;
	logic [3:0] bytes_left;
	logic [3:0] col_offset;
	logic [1:0] cur_bs;
	logic [2:0] cur_as;
	logic pt_wr_phase;
	logic [3:0] col_width;
	logic last_col;
	logic [31:0] row_addr;
	logic [31:0] col_addr;

	// refresh outranks every request while idle
	assign req_ready = (state == TCS_IDLE) && !refresh_pend;
	assign take_refresh = (state == TCS_IDLE) && refresh_pend;
	assign take_req = req_ready && req_valid; // RQ1 RQ11

	assign col_width = 4'h1 << cur_bs; // RQ2
	assign last_col = bytes_left <= col_width;
	assign row_addr = (cur_kind == TCS_K_PT && pt_wr_phase) ? cur_dst_addr : cur_src_addr; // RQ3
	assign col_addr = (row_addr + {28'h0000000, col_offset}) >> cur_as; // RQ23

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_kind <= TCS_K_NORMAL;
			cur_src <= TCS_SRC_UNIT;
			cur_core <= 2'h0;
			cur_sub <= 2'h0;
			cur_chan <= 3'h0;
			cur_frame <= 1'b0;
			cur_write <= 1'b0;
			cur_hi <= 1'b0;
			cur_urgent <= 1'b0;
			cur_src_addr <= 32'h00000000;
			cur_dst_addr <= 32'h00000000;
			cur_bytes <= 4'h0;
		end else if (take_refresh) begin
			cur_kind <= TCS_K_REFRESH; // RQ1
			cur_src <= TCS_SRC_UNIT;
			cur_write <= 1'b0;
			cur_src_addr <= {16'h0000, pseudo_addr};
			cur_bytes <= 4'h1;
		end else if (take_req) begin
			cur_kind <= req_kind; // RQ1 RQ11
			cur_src <= req_src;
			cur_core <= req_core;
			cur_sub <= req_sub;
			cur_chan <= req_chan;
			cur_frame <= req_frame;
			cur_write <= (req_kind == TCS_K_PT) ? 1'b0 : req_write;
			cur_hi <= req_hi_prio;
			cur_urgent <= req_urgent;
			cur_src_addr <= req_src_addr;
			cur_dst_addr <= req_dst_addr; // RQ3
			cur_bytes <= req_bytes;
		end else if (state == TCS_COL && last_col && cur_kind == TCS_K_PT && !pt_wr_phase) begin
			cur_write <= 1'b1; // RQ3
		end
	end

	// bus size and alignment are sampled once per row
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_bs <= 2'h0;
			cur_as <= 3'h0;
			bytes_left <= 4'h0;
			col_offset <= 4'h0;
		end else if (state == TCS_ROW) begin
			cur_bs <= bs_s2; // RQ2
			cur_as <= as_s2; // RQ23
			bytes_left <= cur_bytes;
			col_offset <= 4'h0;
		end else if (state == TCS_COL && !last_col) begin
			bytes_left <= bytes_left - col_width; // RQ2
			col_offset <= col_offset + col_width;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pt_param_words <= 5'h00;
		end else if (take_req && req_kind == TCS_K_PT) begin
			pt_param_words <= req_long_form ? TCS_PARAM_LONG_WORDS : TCS_PARAM_SHORT_WORDS; // RQ11
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			param_word_ord <= 64'h0000000000000000;
		end else if (big_endian) begin
			param_word_ord <= {param_word[31:0], param_word[63:32]}; // RQ12
		end else begin
			param_word_ord <= param_word;
		end
	end

	// ----------------------------------------------------------------
	// block move windows
	// ----------------------------------------------------------------
	logic [31:0] pt_cycles;
	logic [32:0] pt_limit;
	logic is_pt;
	logic preempt;
	logic pt_may_stop;
	logic pt_over;

	assign is_pt = (state != TCS_IDLE) && (cur_kind == TCS_K_PT);
	assign pt_limit = {1'b0, transfer_min_cycles} + {1'b0, transfer_max_cycles};
	assign preempt = refresh_pend || (req_valid && req_kind != TCS_K_PT);
	assign pt_may_stop = is_pt && pt_cycles >= transfer_min_cycles; // RQ6
	assign pt_over = is_pt && {1'b0, pt_cycles} >= pt_limit; // RQ7

	always_ff @(posedge clk) begin
		if (rst) begin
			pt_cycles <= 32'h00000000;
		end else if (!is_pt) begin
			pt_cycles <= 32'h00000000;
		end else begin
			pt_cycles <= pt_cycles + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= TCS_IDLE;
			pt_wr_phase <= 1'b0;
			pt_suspend <= 1'b0;
			pt_timeout <= 1'b0;
			xfer_done <= 1'b0;
		end else begin
			pt_suspend <= 1'b0;
			pt_timeout <= 1'b0;
			xfer_done <= 1'b0;
			unique case (state)
				TCS_IDLE: begin
					pt_wr_phase <= 1'b0;
					if (take_refresh || take_req) begin
						state <= TCS_ROW;
					end
				end
				TCS_ROW: state <= TCS_COL;
				TCS_COL: begin
					if (pt_may_stop && preempt) begin
						state <= TCS_IDLE; // RQ6
						pt_suspend <= 1'b1;
					end else if (pt_over) begin
						state <= TCS_IDLE; // RQ7
						pt_timeout <= 1'b1;
					end else if (last_col) begin
						if (cur_kind == TCS_K_PT && !pt_wr_phase) begin
							pt_wr_phase <= 1'b1; // RQ3
							state <= TCS_ROW;
						end else begin
							state <= TCS_IDLE;
							xfer_done <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// faults and memory outputs
	// ----------------------------------------------------------------
	always_comb begin
		fault_set = '0;
		if (!fault_n_s2 && state == TCS_COL) begin
			unique case (cur_src)
				TCS_SRC_CORE: begin
					if (cur_kind == TCS_K_PT) begin
						fault_set[TCS_FAULT_PT_LSB + int'(cur_core)] = 1'b1; // RQ9
					end else begin
						fault_set[TCS_FAULT_CACHE_LSB + int'(cur_core)] = 1'b1; // RQ9
					end
				end
				TCS_SRC_EXT: fault_set[TCS_FAULT_EXT_BIT] = 1'b1; // RQ9
				TCS_SRC_HOST: fault_set[TCS_FAULT_HOST_BIT] = (cur_kind == TCS_K_PT); // RQ9
				TCS_SRC_UNIT: fault_set = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr <= 32'h00000000;
			mem_row_time <= 1'b0;
			mem_col_time <= 1'b0;
		end else begin
			mem_row_time <= state == TCS_ROW;
			mem_col_time <= state == TCS_COL;
			if (state == TCS_ROW) begin
				mem_addr <= row_addr; // RQ23
			end else if (state == TCS_COL) begin
				mem_addr <= col_addr; // RQ23
			end else begin
				mem_addr <= 32'h00000000;
			end
		end
	end

	tcs_status_code u_status (
		.clk(clk),
		.rst(rst),
		.row_time(state == TCS_ROW),
		.col_time(state == TCS_COL),
		.last_col(last_col),
		.kind(cur_kind),
		.src(cur_src),
		.core(cur_core),
		.sub(cur_sub),
		.chan(cur_chan),
		.frame(cur_frame),
		.write(cur_write),
		.hi_prio(cur_hi),
		.urgent(cur_urgent),
		.status_code(mem_status)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_suspend_min;
		@(posedge clk) disable iff (rst) pt_suspend |-> $past(pt_cycles) >= $past(transfer_min_cycles);
	endproperty
	a_suspend_min: assert property (p_suspend_min) else $error("block move suspended too early"); // RQ6

	property p_timeout_max;
		@(posedge clk) disable iff (rst) pt_timeout |-> {1'b0, $past(pt_cycles)} >= $past(pt_limit);
	endproperty
	a_timeout_max: assert property (p_timeout_max) else $error("block move timed out too early"); // RQ7

	property p_fault_w1c;
		@(posedge clk) disable iff (rst)
			fault_set == '0 && fault_clr != '0 |=> fault_cause == ($past(fault_cause) & ~$past(fault_clr));
	endproperty
	a_fault_w1c: assert property (p_fault_w1c) else $error("fault bit not cleared by write"); // RQ8

	property p_refresh_due;
		@(posedge clk) disable iff (rst) refresh_count == 16'h0000 |=> refresh_pend;
	endproperty
	a_refresh_due: assert property (p_refresh_due) else $error("refresh not requested on expiry"); // RQ5

	property p_row_col;
		@(posedge clk) disable iff (rst) state == TCS_ROW |=> mem_row_time ##1 mem_col_time;
	endproperty
	a_row_col: assert property (p_row_col) else $error("row time not followed by column time"); // RQ13

	property p_row_addr;
		@(posedge clk) disable iff (rst) state == TCS_ROW |=> mem_addr == $past(row_addr);
	endproperty
	a_row_addr: assert property (p_row_addr) else $error("row address not the full address"); // RQ23

	property p_swap;
		@(posedge clk) disable iff (rst)
			big_endian |=> param_word_ord == {$past(param_word[31:0]), $past(param_word[63:32])};
	endproperty
	a_swap: assert property (p_swap) else $error("parameter words not swapped"); // RQ12

endmodule : tcs_controller

// *** dv/tcs_mem_model.sv ***
// tcs_mem_model: external memory pins and bank-decode latch
module tcs_mem_model (
	// clock
	input wire logic clk,
	// bench commands
	input wire logic [1:0] size_cmd,
	input wire logic fault_cmd,
	// memory pins
	input wire logic mem_row_time,
	input wire logic [5:0] mem_status,
	output logic [1:0] mem_bus_size,
	output logic [2:0] mem_align_sel,
	output logic mem_fault_n,
	output logic [5:0] bank_code
);
	timeunit 1ns;
	timeprecision 1ns;
	assign mem_bus_size = size_cmd;
	// column placement follows the bus size so each run sees its own alignment
	assign mem_align_sel = {1'b0, size_cmd};
	assign mem_fault_n = ~fault_cmd;
	// decode keeps the row code for the whole access
	always_ff @(posedge clk) begin
		if (mem_row_time)
			bank_code <= mem_status;
	end
endmodule : tcs_mem_model

// *** dv/tb_tcs_controller.sv ***
// tb_tcs_controller: self-checking bench for the transfer controller
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_tcs_controller;
	timeunit 1ns;
	timeprecision 1ns;
	import tcs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_sel = 1'b0, reg_wr = 1'b0, req_valid = 1'b0, req_frame = 1'b0, req_write = 1'b0;
	logic req_hi_prio = 1'b0, req_urgent = 1'b0, req_long_form = 1'b0, big_endian = 1'b0, fault_cmd = 1'b0;
	logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, req_src_addr = 32'h00001000, req_dst_addr = 32'h0;
	logic [31:0] reg_rdata, mem_addr, rd;
	tcs_kind_t req_kind = TCS_K_NORMAL;
	tcs_src_t req_src = TCS_SRC_CORE;
	logic [1:0] req_core = 2'h0, req_sub = 2'h0, size_cmd = 2'h3, mem_bus_size;
	logic [2:0] req_chan = 3'h0, mem_align_sel;
	logic [3:0] req_bytes = 4'h8;
	logic [63:0] param_word = 64'h0123456789ABCDEF, param_word_ord;
	logic [4:0] pt_param_words;
	logic req_ready, mem_fault_n, mem_row_time, mem_col_time, pt_suspend, pt_timeout, xfer_done;
	logic [5:0] mem_status, bank_code;
	int num_errors = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	tcs_controller DUT (.clk, .rst, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .req_valid, .req_ready,
		.req_kind, .req_src, .req_core, .req_sub, .req_chan, .req_frame, .req_write, .req_hi_prio, .req_urgent,
		.req_long_form, .req_src_addr, .req_dst_addr, .req_bytes, .big_endian, .param_word, .param_word_ord,
		.pt_param_words, .mem_bus_size, .mem_align_sel, .mem_fault_n, .mem_addr, .mem_status, .mem_row_time,
		.mem_col_time, .pt_suspend, .pt_timeout, .xfer_done);
	tcs_mem_model mem (.clk, .size_cmd, .fault_cmd, .mem_row_time, .mem_status, .mem_bus_size, .mem_align_sel,
		.mem_fault_n, .bank_code);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic reg_io(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_sel <= 1'b1;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_sel <= 1'b0;
		@(posedge clk);
		#1 rd = reg_rdata;
	endtask : reg_io
	// ch also picks core, frame and priority mode to keep the call short
	task automatic xfer(input tcs_kind_t k, input tcs_src_t s, input logic [1:0] sub, input logic wr,
		input logic [2:0] ch, input logic [5:0] erow, input logic [5:0] ecol);
		int n;
		@(posedge clk);
		req_kind <= k;
		req_src <= s;
		req_sub <= sub;
		req_write <= wr;
		req_chan <= ch;
		req_core <= ch[1:0];
		req_frame <= ch[0];
		req_hi_prio <= ch[0];
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 300);
		@(posedge clk);
		req_valid <= 1'b0;
		while (mem_row_time !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(mem_status, erow)
		`CHK(mem_addr, req_src_addr)
		@(posedge clk);
		#1 `CHK(mem_col_time, 1'b1)
		`CHK(mem_status, ecol)
		`CHK(mem_addr, req_src_addr >> mem_align_sel)
		`CHK(bank_code, erow)
		while (xfer_done !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n < 300, 1'b1)
	endtask : xfer
	// started just after a refresh row so that no refresh pre-empts the block move
	task automatic pt_run(input logic [31:0] mn, input logic [31:0] mx, input logic sus);
		int n;
		reg_io(1'b1, TCS_ADDR_MIN_CYCLES, mn);
		reg_io(1'b1, TCS_ADDR_MAX_CYCLES, mx);
		n = 0;
		while (!(mem_row_time === 1'b1 && mem_status === 6'h02) && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n < 300, 1'b1)
		@(posedge clk);
		req_kind <= TCS_K_PT;
		req_src <= TCS_SRC_CORE;
		req_long_form <= 1'b1;
		req_valid <= 1'b1;
		do begin
			@(negedge clk);
		end while (req_ready !== 1'b1);
		@(posedge clk);
		if (sus) begin
			req_kind <= TCS_K_NORMAL;
		end else begin
			req_valid <= 1'b0;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (pt_suspend !== 1'b1 && pt_timeout !== 1'b1 && n < 40);
		`CHK(n, sus ? mn + 1 : mn + mx + 1)
		`CHK(pt_suspend, sus)
		`CHK(pt_timeout, !sus)
		`CHK(pt_param_words, 5'h10)
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : pt_run
	initial begin
		#3000000;
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reg_io(1'b0, TCS_ADDR_REFRESH_CONTROL, 32'h0);
		`CHK(rd, 32'h00FF0040)
		reg_io(1'b0, TCS_ADDR_MIN_CYCLES, 32'h0);
		`CHK(rd, 32'h00000010)
		reg_io(1'b0, TCS_ADDR_MAX_CYCLES, 32'h0);
		`CHK(rd, 32'h00000100)
		reg_io(1'b1, TCS_ADDR_MIN_CYCLES, 32'h00000020);
		reg_io(1'b0, TCS_ADDR_MIN_CYCLES, 32'h0);
		`CHK(rd, 32'h00000020)
		reg_io(1'b0, 32'h01820010, 32'h0);
		`CHK(rd, 32'h00000000)
		xfer(TCS_K_NORMAL, TCS_SRC_CORE, 2'h2, 1'b0, 3'h2, 6'h00, 6'h0A);
		xfer(TCS_K_NORMAL, TCS_SRC_HOST, 2'h1, 1'b1, 3'h1, 6'h01, 6'h19);
		xfer(TCS_K_EXT, TCS_SRC_EXT, 2'h1, 1'b0, 3'h3, 6'h2D, 6'h15);
		xfer(TCS_K_FRAME, TCS_SRC_UNIT, 2'h2, 1'b0, 3'h1, 6'h16, 6'h1D);
		@(posedge clk);
		size_cmd <= 2'h0;
		fault_cmd <= 1'b1;
		big_endian <= 1'b1;
		repeat (3) @(posedge clk);
		#1 `CHK(param_word_ord, 64'h89ABCDEF01234567)
		// byte bus: eight columns, fault held low throughout
		xfer(TCS_K_NORMAL, TCS_SRC_CORE, 2'h3, 1'b0, 3'h1, 6'h00, 6'h07);
		@(posedge clk);
		fault_cmd <= 1'b0;
		reg_io(1'b0, TCS_ADDR_FAULT_CAUSE, 32'h0);
		`CHK(rd, 32'h00000002)
		reg_io(1'b1, TCS_ADDR_FAULT_CAUSE, 32'h00000002);
		reg_io(1'b0, TCS_ADDR_FAULT_CAUSE, 32'h0);
		`CHK(rd, 32'h00000000)
		pt_run(32'h00000001, 32'h00000002, 1'b0);
		pt_run(32'h00000002, 32'h00000010, 1'b1);
		finish_test();
	end
endmodule : tb_tcs_controller
